// >>> dv/asr_checker.sv
// concurrent checks on the status word ports
module asr_checker
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic lock_state,
    input wire logic resync_pulse,
    input wire logic map_crc_change_pulse,
    input wire logic input_crc_error_pulse,
    input wire logic crc_type_cfg,
    input wire logic [1:0] word_size_cfg,
    input wire logic [asr_pkg::ASR_CHANNELS-1:0] chan_new_data_pulse,
    input wire logic [asr_pkg::ASR_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [15:0] status_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_rd_status;
        reg_rd && reg_addr == asr_pkg::ASR_STATUS_ADDR;
    endsequence
    sequence s_clear_seen;
        ##2 !status_word[10];
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered after one cycle");
    a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without a read");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr != 6'h01 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rsvd_zero: assert property (
        status_word[7:4] == 4'h0 && reg_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    // levels reach the status word two edges later, and only once reset has been gone that long
    a_lock_track: assert property (
        $past(rst_b, 2) |-> status_word[15] == $past(lock_state, 2))
        else $error("lock bit does not follow lock state");
    a_crc_type: assert property (
        $past(rst_b, 2) |-> status_word[11] == $past(crc_type_cfg, 2))
        else $error("crc type bit wrong");
    a_word_size: assert property (
        $past(rst_b, 2) |-> status_word[9:8] == $past(word_size_cfg, 2))
        else $error("word size field wrong");
    a_resync_set: assert property (resync_pulse |-> ##2 status_word[14])
        else $error("resync flag not set");
    a_map_crc_set: assert property (map_crc_change_pulse |-> ##2 status_word[13])
        else $error("map crc flag not set");
    a_crc_err_set: assert property (input_crc_error_pulse |-> ##2 status_word[12])
        else $error("input crc error flag not set");
    a_chan_set: assert property (
        (|chan_new_data_pulse) |->
        ##2 (&(status_word[3:0] | ~$past(chan_new_data_pulse, 2))))
        else $error("new data flag not set");
    a_rst_flag_clear: assert property (s_rd_status |-> s_clear_seen)
        else $error("reset flag not cleared by read");
    a_rst_flag_once: assert property (!$rose(status_word[10]))
        else $error("reset flag set again");
    a_write_ignored: assert property (reg_wr && !reg_rd |=> $stable(reg_rdata))
        else $error("write changed read data");
endmodule

bind asr_status asr_checker u_chk (.sys_clk, .rst_b, .lock_state, .resync_pulse,
    .map_crc_change_pulse, .input_crc_error_pulse, .crc_type_cfg, .word_size_cfg,
    .chan_new_data_pulse, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_rvalid, .status_word);

// >>> dv/asr_host.sv
// host model driving the register access port on falling edges
module asr_host
(
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [asr_pkg::ASR_ADDR_W-1:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        reg_addr = '0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = '0;
    end
    task automatic read(input logic [5:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = '0;
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        // answer is bounded so a silent design cannot hang the run
        for (int n = 0; n < 4 && ok == 1'b0; n++)
        begin
            if (reg_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata;
            end
            else
                @(negedge sys_clk);
        end
    endtask
    task automatic write(input logic [5:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
endmodule

// >>> dv/test_adc_status_register.sv
// self-checking bench for the converter status word
module test_adc_status_register;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic lock_state = 1'b0;
    logic crc_type_cfg = 1'b0;
    logic [1:0] word_size_cfg = 2'h1;
    logic [2:0] evt = 3'h0;
    logic [3:0] nd = 4'h0;
    logic [3:0] taken = 4'h0;
    logic [95:0] samp = '0;
    logic [5:0] reg_addr;
    logic reg_rd, reg_wr, reg_rvalid;
    logic [15:0] reg_wdata, reg_rdata, status_word;
    logic [127:0] chan_word;
    int err_count = 0;
    int cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    asr_status DUT (.sys_clk, .rst_b, .lock_state, .resync_pulse(evt[2]),
        .map_crc_change_pulse(evt[1]), .input_crc_error_pulse(evt[0]), .crc_type_cfg,
        .word_size_cfg, .chan_new_data_pulse(nd), .chan_data_taken(taken), .chan_sample(samp),
        .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .status_word,
        .chan_word);
    asr_host host (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
    // ------------------------------------------------------------------
    // compare, access and closing tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read(a, d, ok);
        if (ok !== 1'b1)
        begin
            err_count++;
            results();
        end
        else
            chk("reg_rdata", {16'h0, exp}, {16'h0, d});
    endtask
    initial
    begin
        repeat (4) @(negedge sys_clk);
        rst_b = 1'b1;
        rd(6'h01, 16'h0500);
        rd(6'h01, 16'h0100);
        rd(6'h02, 16'h0000);
        host.write(6'h01, 16'hffff);
        rd(6'h01, 16'h0100);
        lock_state = 1'b1;
        crc_type_cfg = 1'b1;
        for (int w = 0; w < 4; w++)
        begin
            word_size_cfg = 2'(w);
            rd(6'h01, 16'h8800 | (16'(w) << 8));
        end
        for (int i = 0; i < 3; i++)
        begin
            @(negedge sys_clk);
            evt[i] = 1'b1;
            @(negedge sys_clk);
            evt[i] = 1'b0;
            rd(6'h01, 16'h8b00 | (16'h1000 << i));
            rd(6'h01, 16'h8b00);
        end
        for (int c = 0; c < 4; c++)
        begin
            @(negedge sys_clk);
            samp[24*c +: 24] = 24'h800000 | 24'(c);
            nd[c] = 1'b1;
            @(negedge sys_clk);
            nd[c] = 1'b0;
            chk("chan_word", 32'hff800000 | 32'(c), chan_word[32*c +: 32]);
            rd(6'h01, 16'h8b00 | (16'h1 << c));
            @(negedge sys_clk);
            taken[c] = 1'b1;
            @(negedge sys_clk);
            taken[c] = 1'b0;
            rd(6'h01, 16'h8b00);
        end
        chk("status_word", 32'h0000_8b00, {16'h0, status_word});
        word_size_cfg = 2'h2;
        @(negedge sys_clk);
        samp[23:0] = 24'h123456;
        nd[0] = 1'b1;
        @(negedge sys_clk);
        nd[0] = 1'b0;
        chk("chan_word", 32'h12345600, chan_word[31:0]);
        // a second reset in mid-run brings back the reset word and bit 10
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("status_word", 32'h0000_0500, {16'h0, status_word});
        rst_b = 1'b1;
        rd(6'h01, 16'h8e00);
        rd(6'h01, 16'h8a00);
        results();
    end
endmodule

// >>> verilog/asr_flag.sv
// sticky event flag whose set beats a simultaneous clear
module asr_flag
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag
);

    typedef struct packed
    {
        logic flag;
    } asr_flag_st_t;

    asr_flag_st_t st_r;
    asr_flag_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (set_pulse)
        begin
            st_nxt.flag = 1'b1;
        end
        else if (clr_pulse)
        begin
            st_nxt.flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{flag: RESET_VAL};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag;

endmodule

// >>> verilog/asr_fmt.sv
// packs one 24-bit conversion result into an output word per word size code
module asr_fmt
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [1:0] word_size_code,
    input wire logic [asr_pkg::ASR_SAMPLE_W-1:0] sample,
    output logic [asr_pkg::ASR_WORD_W-1:0] word
);

    typedef struct packed
    {
        logic [asr_pkg::ASR_WORD_W-1:0] word;
    } asr_fmt_st_t;

    asr_fmt_st_t st_r;
    asr_fmt_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (load)
        begin
            case (word_size_code)
                asr_pkg::ASR_WLEN_16:
                begin
                    st_nxt.word = {16'h0000, sample[23:8]};
                end
                asr_pkg::ASR_WLEN_24:
                begin
                    st_nxt.word = {8'h00, sample};
                end
                asr_pkg::ASR_WLEN_32_ZERO:
                begin
                    st_nxt.word = {sample, 8'h00};
                end
                asr_pkg::ASR_WLEN_32_SIGN:
                begin
                    st_nxt.word = {{8{sample[23]}}, sample};
                end
                default:
                begin
                    st_nxt.word = {8'h00, sample};
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{word: 32'h0000_0000};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign word = st_r.word;

endmodule

// >>> verilog/asr_pkg.sv
// constants shared by the converter status word logic
package asr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ASR_ADDR_W = 6;
    localparam logic [5:0] ASR_STATUS_ADDR = 6'h01;
    localparam logic [15:0] ASR_STATUS_RESET = 16'h0500;
    localparam logic [15:0] ASR_UNMAPPED_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // field positions of the status word
    // ------------------------------------------------------------------
    localparam int ASR_LOCK_BIT = 15;
    localparam int ASR_RESYNC_BIT = 14;
    localparam int ASR_MAPCRC_BIT = 13;
    localparam int ASR_CRCERR_BIT = 12;
    localparam int ASR_CRCTYPE_BIT = 11;
    localparam int ASR_RSTOCC_BIT = 10;
    localparam int ASR_WLEN_LSB = 8;
    localparam int ASR_RSVD_LSB = 4;
    localparam int ASR_NEWDATA_LSB = 0;

    // ------------------------------------------------------------------
    // field values and reset values
    // ------------------------------------------------------------------
    localparam logic ASR_LOCK_RESET = 1'b0;
    localparam logic ASR_CRC_CCITT = 1'b0;
    localparam logic ASR_CRC_ANSI = 1'b1;
    localparam logic ASR_RSTOCC_RESET = 1'b1;
    localparam logic ASR_FLAG_RESET = 1'b0;
    localparam logic [3:0] ASR_RSVD_VALUE = 4'h0;
    localparam logic [1:0] ASR_WLEN_16 = 2'h0;
    localparam logic [1:0] ASR_WLEN_24 = 2'h1;
    localparam logic [1:0] ASR_WLEN_32_ZERO = 2'h2;
    localparam logic [1:0] ASR_WLEN_32_SIGN = 2'h3;
    localparam logic [1:0] ASR_WLEN_RESET = 2'h1;

    // ------------------------------------------------------------------
    // data path sizes
    // ------------------------------------------------------------------
    localparam int ASR_CHANNELS = 4;
    localparam int ASR_SAMPLE_W = 24;
    localparam int ASR_WORD_W = 32;

endpackage

// >>> verilog/asr_status.sv
// status word of the converter host interface with per-channel output words
//
// Behaviour
// - status word lives at register address 1h and resets to 0500h.
// - bit 15 shows interface lock state; zero after reset.
// - bit 14 sets on each converter resynchronization; zero after reset.
// - bit 13 sets when register map checksum changes; zero after reset.
// - bit 12 sets on input data CRC error; zero after reset.
// - bit 11 shows CRC polynomial, 0 CCITT default, 1 ANSI.
// - bit 10 reads 1 after a reset, 0 once the status word has been read.
// - bits 9:8 show word length: 16, 24 default, 32 zero padded.
// - code 11b gives 32-bit words with sign extended 24-bit results.
// - reserved bits 7:4 always read 0000b.
// - bit 3 shows channel 3 new data; zero after reset.
// - bit 2 shows channel 2 new data; zero after reset.
module asr_status
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic lock_state,
    input wire logic resync_pulse,
    input wire logic map_crc_change_pulse,
    input wire logic input_crc_error_pulse,
    input wire logic crc_type_cfg,
    input wire logic [1:0] word_size_cfg,
    input wire logic [asr_pkg::ASR_CHANNELS-1:0] chan_new_data_pulse,
    input wire logic [asr_pkg::ASR_CHANNELS-1:0] chan_data_taken,
    input wire logic [asr_pkg::ASR_CHANNELS*asr_pkg::ASR_SAMPLE_W-1:0] chan_sample,
    input wire logic [asr_pkg::ASR_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic [15:0] status_word,
    output logic [asr_pkg::ASR_CHANNELS*asr_pkg::ASR_WORD_W-1:0] chan_word
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [15:0] rdata;
        logic rvalid;
        logic [15:0] status;
        logic lock;
        logic crc_type;
        logic [1:0] word_size_code;
    } asr_status_st_t;

    asr_status_st_t st_r;
    asr_status_st_t st_nxt;

    logic status_hit;
    logic status_read;
    logic resync_event_flag;
    logic map_crc_flag;
    logic input_crc_flag;
    logic reset_seen_flag;
    logic [asr_pkg::ASR_CHANNELS-1:0] new_data_flag;
    logic [15:0] word_now;
    logic write_ignored;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign status_hit = (reg_addr == asr_pkg::ASR_STATUS_ADDR);
    assign status_read = reg_rd && status_hit;
    // writes reach no storage in this block
    assign write_ignored = reg_wr && status_hit && (reg_wdata != 16'h0000);

    // ------------------------------------------------------------------
    // sticky event flags, cleared by a host read of the status word
    // ------------------------------------------------------------------
    asr_flag #(.RESET_VAL(asr_pkg::ASR_FLAG_RESET)) u_resync
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .set_pulse(resync_pulse),
        .clr_pulse(status_read),
        .flag(resync_event_flag)
    );

    asr_flag #(.RESET_VAL(asr_pkg::ASR_FLAG_RESET)) u_map_crc
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .set_pulse(map_crc_change_pulse),
        .clr_pulse(status_read),
        .flag(map_crc_flag)
    );

    asr_flag #(.RESET_VAL(asr_pkg::ASR_FLAG_RESET)) u_in_crc
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .set_pulse(input_crc_error_pulse),
        .clr_pulse(status_read),
        .flag(input_crc_flag)
    );

    // set out of reset, dropped by the first status read
    asr_flag #(.RESET_VAL(asr_pkg::ASR_RSTOCC_RESET)) u_reset_seen
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .set_pulse(1'b0),
        .clr_pulse(status_read),
        .flag(reset_seen_flag)
    );

    // ------------------------------------------------------------------
    // per-channel new data flags and output words
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < asr_pkg::ASR_CHANNELS; ch = ch + 1)
        begin : g_chan
            asr_flag #(.RESET_VAL(asr_pkg::ASR_FLAG_RESET)) u_new_data
            (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .set_pulse(chan_new_data_pulse[ch]),
                .clr_pulse(chan_data_taken[ch]),
                .flag(new_data_flag[ch])
            );

            asr_fmt u_fmt
            (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .load(chan_new_data_pulse[ch]),
                .word_size_code(st_r.word_size_code),
                .sample(chan_sample[ch*asr_pkg::ASR_SAMPLE_W +: asr_pkg::ASR_SAMPLE_W]),
                .word(chan_word[ch*asr_pkg::ASR_WORD_W +: asr_pkg::ASR_WORD_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // status word assembly
    // ------------------------------------------------------------------
    always_comb
    begin
        word_now = 16'h0000;
        word_now[asr_pkg::ASR_LOCK_BIT] = st_r.lock;
        word_now[asr_pkg::ASR_RESYNC_BIT] = resync_event_flag;
        word_now[asr_pkg::ASR_MAPCRC_BIT] = map_crc_flag;
        word_now[asr_pkg::ASR_CRCERR_BIT] = input_crc_flag;
        word_now[asr_pkg::ASR_CRCTYPE_BIT] = st_r.crc_type;
        word_now[asr_pkg::ASR_RSTOCC_BIT] = reset_seen_flag;
        word_now[asr_pkg::ASR_WLEN_LSB +: 2] = st_r.word_size_code;
        word_now[asr_pkg::ASR_RSVD_LSB +: 4] = asr_pkg::ASR_RSVD_VALUE;
        word_now[asr_pkg::ASR_NEWDATA_LSB +: 4] = new_data_flag;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.lock = lock_state;
        st_nxt.crc_type = crc_type_cfg;
        st_nxt.word_size_code = word_size_cfg;
        st_nxt.status = word_now;
        st_nxt.rvalid = reg_rd;
        if (reg_rd)
        begin
            if (status_hit)
            begin
                st_nxt.rdata = word_now;
            end
            else
            begin
                st_nxt.rdata = asr_pkg::ASR_UNMAPPED_DATA;
            end
        end
        if (write_ignored)
        begin
            st_nxt.status = word_now;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '{rdata: 16'h0000,
                      rvalid: 1'b0,
                      status: asr_pkg::ASR_STATUS_RESET,
                      lock: asr_pkg::ASR_LOCK_RESET,
                      crc_type: asr_pkg::ASR_CRC_CCITT,
                      word_size_code: asr_pkg::ASR_WLEN_RESET};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign status_word = st_r.status;

endmodule
